// >>> hw/pmc_pkg.sv
// package: register layout, reset values and timing counts of the power mode controller
package pmc_pkg;
   // apb byte offset of the power control register
   localparam logic [7:0] PWR_CTRL_OFF = 8'h00;
   // read-only status word: mode, settling, wake cause
   localparam logic [7:0] PWR_STAT_OFF = 8'h04;
   // field positions in power_control_reg
   localparam int BAUD_DOUBLE_POS = 7;
   localparam int FRAME_ERR_SEL_POS = 6;
   localparam int RSVD_POS = 5;
   localparam int POWER_ON_FLAG_POS = 4;
   localparam int GEN_FLAG_HI_POS = 3;
   localparam int GEN_FLAG_LO_POS = 2;
   localparam int POWERDOWN_POS = 1;
   localparam int IDLE_POS = 0;
   // reset value: power-on flag set, everything else clear
   localparam logic [7:0] PWR_CTRL_RST = 8'h10;
   // bits that software can write; bit 5 stays zero
   localparam logic [7:0] PWR_CTRL_WMASK = 8'hDF;
   // clock figures
   localparam int CLK_FREQ_HZ = 50000000;
   localparam int SETTLE_COUNTS = 32768;
   localparam int RESET_IDLE_CLOCKS = 24;
   localparam int RESET_PD_MS = 10;
   localparam int RESET_PD_CYCLES = RESET_PD_MS * (CLK_FREQ_HZ / 1000);
   localparam int PD_GUARD_US = 4;
   localparam int PD_GUARD_CYCLES = PD_GUARD_US * (CLK_FREQ_HZ / 1000000);
   // execution resumes here after a reset wake-up
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   // number of wake pins: four irq, receive, two counters
   localparam int WAKE_PINS = 7;
   typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_PDOWN, PMC_SETTLE} pmc_state_t;
endpackage : pmc_pkg

// >>> hw/pmc_wake_edge.sv
// module: falling-edge detector for one wake pin
`timescale 1ns/1ns
module pmc_wake_edge
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pin,
   output logic fall
);
   logic prev_r;

   // previous level; pins are already synchronous
   always_ff @(posedge core_clk)
   begin
      if (rst)
         prev_r <= 1'b1;
      else
         prev_r <= pin;
   end

   // one-cycle pulse on a high to low step
   assign fall = prev_r & ~pin;
endmodule : pmc_wake_edge

// >>> hw/pmc_power_ctrl.sv
// module: power mode controller with apb access to the power control register
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
// How it works
// - bit 7 set doubles serial baud rate in modes 1, 2, 3.
// - bit 6 selects frame error or mode role for serial control bit 7.
// - power-on flag set by power cycle, cleared only by software write.
// - general flags 3 and 2 are read/write and survive idle.
// - setting idle bit ends execution; cpu clock gated, peripherals clocked.
// - cpu state and port pins frozen while idle.
// - address latch and program read strobes held high in idle.
// - enabled interrupt in idle clears idle bit and resumes execution.
// - reset pin high 24 clocks resets and leaves idle.
// - setting powerdown bit stops oscillator and flash; state retained.
// - power-down exits by reset, four irq pins, receive, two counters.
// - reset wake-up starts at 0x0000; reset held at least 10 ms (code fires after 24 clocks high in power-down too).
// - falling edge on enabled wake pin restarts oscillator, starts counter.
// - cpu clock blocked until 32768 counts, then vector to interrupt.
module pmc_power_ctrl
#(
   parameter int SETTLE_CNT = pmc_pkg::SETTLE_COUNTS,
   parameter int RST_IDLE_CNT = pmc_pkg::RESET_IDLE_CLOCKS
)
(
   input wire logic core_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device reset pin and power-cycle indication
   input wire logic reset_pin,
   input wire logic power_cycle,
   // wake sources: ext_irq_pin_0..3, serial receive, counter_input_0/1
   input wire logic ext_irq_pin_0,
   input wire logic ext_irq_pin_1,
   input wire logic ext_irq_pin_2,
   input wire logic ext_irq_pin_3,
   input wire logic rx_pin,
   input wire logic counter_input_0,
   input wire logic counter_input_1,
   input wire logic [6:0] wake_enable,
   // interrupt controller view
   input wire logic irq_pending,
   // clocking and core control
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_en,
   output logic flash_en,
   output logic core_hold,
   output logic port_hold,
   output logic ale_force_high,
   output logic prog_store_read_strobe_force_high,
   output logic core_reset,
   output logic [15:0] restart_vector,
   output logic wake_vector_req,
   output logic [6:0] wake_source,
   output logic baud_double_bit,
   output logic frame_error_select_bit,
   output logic general_flag_hi,
   output logic general_flag_lo
);
   logic [7:0] power_control_reg_r;
   pmc_pkg::pmc_state_t state_r;
   logic [15:0] settle_cnt_r;
   logic [4:0] rst_cnt_r;
   logic core_reset_r;
   logic [6:0] wake_src_r;
   logic wake_req_r;
   logic [31:0] prdata_r;
   logic [6:0] wake_pins;
   logic [6:0] wake_fall;
   logic wr_ctrl;
   logic rd_en;
   logic wake_edge;
   logic settle_done;
   logic [7:0] wdata8;

   assign wake_pins = {counter_input_1, counter_input_0, rx_pin, ext_irq_pin_3,
                       ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0};

   // one edge detector per wake pin
   genvar gi;
   generate
      for (gi = 0; gi < pmc_pkg::WAKE_PINS; gi++)
      begin : g_wake
         pmc_wake_edge u_edge
         (
            .core_clk(core_clk),
            .rst(rst),
            .pin(wake_pins[gi]),
            .fall(wake_fall[gi])
         );
      end
   endgenerate

   // apb decode: zero wait states, unmapped reads give zero
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_ctrl = psel & penable & pwrite & (paddr == pmc_pkg::PWR_CTRL_OFF);
   assign rd_en = psel & ~penable & ~pwrite;
   assign wdata8 = pwdata[7:0] & pmc_pkg::PWR_CTRL_WMASK; // bit 5 ignored
   assign wake_edge = |(wake_fall & wake_enable); // only enabled pins wake
   assign settle_done = (settle_cnt_r == 16'(SETTLE_CNT - 1));

   // reset pin must stay high for the full count before reset fires
   always_ff @(posedge core_clk)
   begin
      if (rst || !reset_pin)
         rst_cnt_r <= '0;
      else if (rst_cnt_r != 5'(RST_IDLE_CNT))
         rst_cnt_r <= rst_cnt_r + 5'h01;
   end

   // reset pulse after 24 clocks high; oscillator runs in idle
   always_ff @(posedge core_clk)
   begin
      if (rst)
         core_reset_r <= 1'b1;
      else
         core_reset_r <= reset_pin && (rst_cnt_r >= 5'(RST_IDLE_CNT - 1));
   end

   // power control register
   always_ff @(posedge core_clk)
   begin
      if (rst)
         power_control_reg_r <= pmc_pkg::PWR_CTRL_RST;
      else
      begin
         if (wr_ctrl)
            power_control_reg_r <= wdata8; // flags written freely
         // power-on flag: set wins over a clearing write
         if (power_cycle)
            power_control_reg_r[pmc_pkg::POWER_ON_FLAG_POS] <= 1'b1;
         // hardware clears mode bits on wake; flags untouched
         if ((state_r == pmc_pkg::PMC_IDLE) && irq_pending)
            power_control_reg_r[pmc_pkg::IDLE_POS] <= 1'b0;
         if ((state_r == pmc_pkg::PMC_SETTLE) && settle_done)
         begin
            power_control_reg_r[pmc_pkg::POWERDOWN_POS] <= 1'b0;
            power_control_reg_r[pmc_pkg::IDLE_POS] <= 1'b0;
         end
         // core reset drops both modes, keeps power-on flag
         if (core_reset_r)
            power_control_reg_r[1:0] <= 2'b00;
      end
   end

   // mode sequencing
   always_ff @(posedge core_clk)
   begin
      if (rst || core_reset_r)
         state_r <= pmc_pkg::PMC_RUN; // reset wakes from any mode
      else
      begin
         case (state_r)
            pmc_pkg::PMC_RUN:
            begin
               // the write is the last instruction run
               if (wr_ctrl && wdata8[pmc_pkg::POWERDOWN_POS])
                  state_r <= pmc_pkg::PMC_PDOWN; // powerdown wins
               else if (wr_ctrl && wdata8[pmc_pkg::IDLE_POS])
                  state_r <= pmc_pkg::PMC_IDLE;
            end
            pmc_pkg::PMC_IDLE:
               if (irq_pending)
                  state_r <= pmc_pkg::PMC_RUN;
            pmc_pkg::PMC_PDOWN:
               if (wake_edge)
                  state_r <= pmc_pkg::PMC_SETTLE;
            pmc_pkg::PMC_SETTLE:
               if (settle_done)
                  state_r <= pmc_pkg::PMC_RUN;
            default:
               state_r <= pmc_pkg::PMC_RUN;
         endcase
      end
   end

   // settling counter, runs only while the restarted oscillator settles
   always_ff @(posedge core_clk)
   begin
      if (rst || state_r != pmc_pkg::PMC_SETTLE)
         settle_cnt_r <= '0;
      else if (!settle_done)
         settle_cnt_r <= settle_cnt_r + 16'h0001;
   end

   // latch wake cause and request the matching interrupt vector
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         wake_src_r <= '0;
         wake_req_r <= 1'b0;
      end
      else
      begin
         if (state_r == pmc_pkg::PMC_PDOWN && wake_edge)
            wake_src_r <= wake_fall & wake_enable;
         // vector only once the clock is released
         wake_req_r <= (state_r == pmc_pkg::PMC_SETTLE) && settle_done;
      end
   end

   // apb read data, taken in setup so it stands through access
   always_ff @(posedge core_clk)
   begin
      if (rst)
         prdata_r <= '0;
      else if (rd_en)
      begin
         case (paddr)
            pmc_pkg::PWR_CTRL_OFF: prdata_r <= {24'h000000, power_control_reg_r};
            pmc_pkg::PWR_STAT_OFF: prdata_r <= {16'h0000, settle_cnt_r[15:9],
                                                wake_src_r, state_r};
            default: prdata_r <= '0;
         endcase
      end
   end
   assign prdata = prdata_r;

   // clock gating: peripherals run in idle, everything stops in power-down
   assign cpu_clk_en = (state_r == pmc_pkg::PMC_RUN);
   assign periph_clk_en = (state_r == pmc_pkg::PMC_RUN) || (state_r == pmc_pkg::PMC_IDLE);
   assign osc_en = (state_r != pmc_pkg::PMC_PDOWN);
   assign flash_en = (state_r == pmc_pkg::PMC_RUN) || (state_r == pmc_pkg::PMC_IDLE);
   // freeze core registers and pins; ram and sfrs retained
   assign core_hold = (state_r != pmc_pkg::PMC_RUN);
   assign port_hold = (state_r != pmc_pkg::PMC_RUN);
   // steady high strobes in idle
   assign ale_force_high = (state_r == pmc_pkg::PMC_IDLE);
   assign prog_store_read_strobe_force_high = (state_r == pmc_pkg::PMC_IDLE);
   assign core_reset = core_reset_r;
   assign restart_vector = pmc_pkg::RESET_VECTOR;
   assign wake_vector_req = wake_req_r;
   assign wake_source = wake_src_r;
   // serial port controls and general flags
   assign baud_double_bit = power_control_reg_r[pmc_pkg::BAUD_DOUBLE_POS];
   assign frame_error_select_bit = power_control_reg_r[pmc_pkg::FRAME_ERR_SEL_POS];
   assign general_flag_hi = power_control_reg_r[pmc_pkg::GEN_FLAG_HI_POS];
   assign general_flag_lo = power_control_reg_r[pmc_pkg::GEN_FLAG_LO_POS];

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   pof_set_wins_a: assert property (power_cycle |=> power_control_reg_r[4])
      else $error("power-on flag not set");
   rsvd_zero_a: assert property (power_control_reg_r[5] == 1'b0)
      else $error("reserved bit not zero");
   pd_priority_a: assert property ((state_r == pmc_pkg::PMC_RUN) && wr_ctrl && wdata8[1]
      && !core_reset_r |=> state_r == pmc_pkg::PMC_PDOWN)
      else $error("powerdown did not win");
   idle_strobe_a: assert property (state_r == pmc_pkg::PMC_IDLE |-> ale_force_high
      && prog_store_read_strobe_force_high && periph_clk_en && !cpu_clk_en)
      else $error("idle outputs wrong");
   idle_wake_a: assert property ((state_r == pmc_pkg::PMC_IDLE) && irq_pending
      && !core_reset_r |=> !power_control_reg_r[0] && cpu_clk_en)
      else $error("idle not ended by interrupt");
   reset_len_a: assert property ($rose(reset_pin) ##0 reset_pin [*8]
      |-> !core_reset_r)
      else $error("reset fired too early");
   reset_fire_a: assert property (reset_pin [*8] ##1 reset_pin [*8] ##1 reset_pin [*8]
      |=> core_reset_r)
      else $error("reset did not fire");
   pd_osc_a: assert property (state_r == pmc_pkg::PMC_PDOWN
      |-> !osc_en && !flash_en)
      else $error("oscillator running in power-down");
   settle_hold_a: assert property (state_r == pmc_pkg::PMC_SETTLE
      |-> !cpu_clk_en && osc_en)
      else $error("cpu clock released while settling");
   settle_len_a: assert property ($rose(wake_vector_req) |->
      $past(settle_cnt_r) == 16'(SETTLE_CNT - 1))
      else $error("settling count wrong");
   pd_wake_a: assert property ((state_r == pmc_pkg::PMC_PDOWN) && wake_edge && !core_reset_r
      |=> state_r == pmc_pkg::PMC_SETTLE)
      else $error("wake edge ignored");

   // a core reset always lands in run
   core_rst_run_a: assert property (core_reset_r |=> state_r == pmc_pkg::PMC_RUN)
      else $error("core reset left a low power mode");

   // and drops both mode bits, whatever the bus wrote
   rst_bits_a: assert property (core_reset_r |=> power_control_reg_r[1:0] == 2'b00)
      else $error("core reset kept a mode bit");

   // power-on flag falls only through a software write
   pof_clear_a: assert property (power_control_reg_r[pmc_pkg::POWER_ON_FLAG_POS]
      && !wr_ctrl |=> power_control_reg_r[pmc_pkg::POWER_ON_FLAG_POS])
      else $error("power-on flag cleared by hardware");

   // general flags move only on a write, idle included
   flags_keep_a: assert property (!wr_ctrl |=> $stable(power_control_reg_r[3:2]))
      else $error("general flags changed without a write");

   // register contents survive power-down
   pd_retain_a: assert property ((state_r == pmc_pkg::PMC_PDOWN) && !wr_ctrl
      && !power_cycle |=> $stable(power_control_reg_r[7:2]))
      else $error("register contents lost in power-down");

   // core state and pins frozen in idle
   idle_hold_a: assert property (state_r == pmc_pkg::PMC_IDLE
      |-> core_hold && port_hold)
      else $error("core not frozen in idle");

   // address latch strobe is only forced while idle
   run_strobe_a: assert property (state_r != pmc_pkg::PMC_IDLE |-> !ale_force_high)
      else $error("strobe forced outside idle");

   // vector request is a single pulse
   wake_pulse_a: assert property (wake_vector_req |=> !wake_vector_req)
      else $error("wake request longer than one cycle");

   // settling counter steps by one each cycle
   settle_step_a: assert property ((state_r == pmc_pkg::PMC_SETTLE) && !settle_done
      |=> settle_cnt_r == 16'($past(settle_cnt_r) + 16'h0001))
      else $error("settling counter skipped");

   idle_cov_c: cover property (state_r == pmc_pkg::PMC_IDLE ##1 state_r == pmc_pkg::PMC_RUN);
   pd_cov_c: cover property (state_r == pmc_pkg::PMC_PDOWN ##1 state_r == pmc_pkg::PMC_SETTLE);
   wake_cov_c: cover property (wake_vector_req);
   rst_cov_c: cover property (core_reset_r && state_r == pmc_pkg::PMC_IDLE);
   settle_cov_c: cover property (state_r == pmc_pkg::PMC_SETTLE ##1 state_r == pmc_pkg::PMC_RUN);
endmodule : pmc_power_ctrl

// >>> test/pmc_wake_model.sv
// wake pin and reset pin source standing outside the power mode controller
`timescale 1ns/1ns
module pmc_wake_model
(
   input wire logic core_clk,
   input wire logic wake_vector_req,
   output logic [6:0] pins,
   output logic reset_pin
);
   // port pins idle high through their pull-ups, reset pin idles low
   initial
   begin
      pins = 7'h7F;
      reset_pin = 1'b0;
   end

   // pull one pin low and keep it low until the core has restarted or lim cycles have passed
   task automatic wake(input int idx, input int lim);
      int n;
      n = 0;
      @(posedge core_clk);
      pins[idx] <= 1'b0;
      @(posedge core_clk);
      while (wake_vector_req !== 1'b1 && n < lim)
      begin
         @(posedge core_clk);
         n++;
      end
      repeat (2) @(posedge core_clk); // held past the end of settling
      pins[idx] <= 1'b1;
   endtask : wake

   // hold the reset pin high for a given number of clock edges
   task automatic press(input int n);
      @(posedge core_clk);
      reset_pin <= 1'b1;
      repeat (n) @(posedge core_clk);
      reset_pin <= 1'b0;
   endtask : press
endmodule : pmc_wake_model

// >>> test/testbench.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ns
module testbench;
   localparam int SETTLE = 16;
   localparam logic [7:0] CTRL = pmc_pkg::PWR_CTRL_OFF;
   localparam logic [7:0] STAT = pmc_pkg::PWR_STAT_OFF;
   logic core_clk, rst, psel, penable, pwrite, power_cycle, irq_pending, seen_rst;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] pins, wake_enable, wake_source;
   logic pready, pslverr, reset_pin, cpu_clk_en, periph_clk_en, osc_en, flash_en, core_hold;
   logic port_hold, ale_hi, strobe_hi, core_reset, wake_vector_req, baud, fesel, gf_hi, gf_lo;
   logic [15:0] restart_vector;
   int num_errors, num_checks, cycles;

   // settle count shortened so each wake-up takes a few cycles
   pmc_power_ctrl #(.SETTLE_CNT(SETTLE), .RST_IDLE_CNT(24)) uut
   (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_pin(reset_pin), .power_cycle(power_cycle), .ext_irq_pin_0(pins[0]),
      .ext_irq_pin_1(pins[1]), .ext_irq_pin_2(pins[2]), .ext_irq_pin_3(pins[3]),
      .rx_pin(pins[4]), .counter_input_0(pins[5]), .counter_input_1(pins[6]),
      .wake_enable(wake_enable), .irq_pending(irq_pending), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .osc_en(osc_en), .flash_en(flash_en),
      .core_hold(core_hold), .port_hold(port_hold), .ale_force_high(ale_hi),
      .prog_store_read_strobe_force_high(strobe_hi), .core_reset(core_reset),
      .restart_vector(restart_vector), .wake_vector_req(wake_vector_req),
      .wake_source(wake_source), .baud_double_bit(baud), .frame_error_select_bit(fesel),
      .general_flag_hi(gf_hi), .general_flag_lo(gf_lo)
   );

   pmc_wake_model pm
   (
      .core_clk(core_clk), .wake_vector_req(wake_vector_req), .pins(pins),
      .reset_pin(reset_pin)
   );

   // free-running 50 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // hang guard, plus a sticky note of any core reset pulse
   always @(posedge core_clk)
   begin
      cycles++;
      if (core_reset === 1'b1)
         seen_rst <= 1'b1;
      if (cycles == 20000)
      begin
         num_errors++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; waits on pready rather than assuming zero wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge core_clk);
         n++;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk

   // only the mode field of the status word is compared
   task automatic stat(input logic [1:0] st);
      apb(1'b0, STAT, 32'h0);
      chk({30'h0, rd[1:0]}, {30'h0, st});
   endtask : stat

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   // main sequence: register bits, idle entry and exits, power-down wake sources
   initial
   begin
      int n;
      {psel, penable, pwrite, power_cycle, irq_pending, seen_rst} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wake_enable = 7'h7E;
      rst = 1'b1;
      cycles = 0;
      num_errors = 0;
      num_checks = 0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rchk(CTRL, 32'h10);
      apb(1'b1, CTRL, 32'hEC);
      rchk(CTRL, 32'hCC);
      chk({28'h0, baud, fesel, gf_hi, gf_lo}, 32'hF);
      rchk(8'h08, 32'h0);
      chk({31'h0, pslverr}, 32'h0);
      @(posedge core_clk);
      power_cycle <= 1'b1;
      @(posedge core_clk);
      power_cycle <= 1'b0;
      rchk(CTRL, 32'hDC);
      apb(1'b1, CTRL, 32'hCC);
      rchk(CTRL, 32'hCC);
      // idle, then a reset pulse one edge short and one of full length
      apb(1'b1, CTRL, 32'hCD);
      stat(2'd1);
      chk({26'h0, core_hold, cpu_clk_en, periph_clk_en, port_hold, ale_hi, strobe_hi},
          32'h2F);
      seen_rst <= 1'b0;
      pm.press(23);
      stat(2'd1);
      chk({31'h0, seen_rst}, 32'h0);
      pm.press(24);
      stat(2'd0);
      chk({31'h0, seen_rst}, 32'h1);
      // idle left by an interrupt, flags survive
      apb(1'b1, CTRL, 32'hCD);
      @(posedge core_clk);
      irq_pending <= 1'b1;
      @(posedge core_clk);
      irq_pending <= 1'b0;
      stat(2'd0);
      rchk(CTRL, 32'hCC);
      // both mode bits at once; a disabled pin must not wake
      repeat (pmc_pkg::PD_GUARD_CYCLES) @(posedge core_clk);
      apb(1'b1, CTRL, 32'h03);
      stat(2'd2);
      chk({30'h0, osc_en, flash_en}, 32'h0);
      pm.wake(0, 40);
      stat(2'd2);
      pm.press(24);
      stat(2'd0);
      chk({16'h0, restart_vector}, 32'h0);
      wake_enable <= 7'h7F;
      for (int i = 0; i < 7; i++)
      begin
         repeat (pmc_pkg::PD_GUARD_CYCLES) @(posedge core_clk);
         apb(1'b1, CTRL, 32'h02);
         n = 0;
         fork
            pm.wake(i, 100);
            begin
               while (wake_vector_req !== 1'b1 && n < 100)
               begin
                  @(posedge core_clk);
                  n++;
                  if (n == 6)
                     chk({30'h0, cpu_clk_en, osc_en}, 32'h1);
               end
               chk({25'h0, wake_source}, 32'h1 << i);
            end
         join
         wake_enable[i] <= 1'b0; // service routine masks its own source
         chk(32'(n >= SETTLE && n <= SETTLE + 6), 32'h1);
         chk({31'h0, wake_vector_req}, 32'h0);
         stat(2'd0);
      end
      complete_run();
   end
endmodule : testbench
